//--- logic/cri_regs.sv
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
// event-request and live-condition registers behind a classic wishbone slave
// assumes condition pins are asynchronous; 8-bit data in the low byte lane
module cri_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        full_speed_link_i,
  input  wire logic        link_suspended_i,
  input  wire logic        terminal_supply_detect_i,
  input  wire logic        card_supply_detect_i,
  input  wire logic        bus_power_detect_i,
  input  wire logic        busy_line_i,
  input  wire logic        card_presence_i,
  input  wire logic        fw_update_event_i,
  output logic             irq_o
);
  typedef struct packed {
    logic [7:0]  test_reg_e;
    logic [7:0]  firmware_portal;
    logic [7:0]  req1;
    logic [7:0]  req2;
    logic [7:0]  enable1;
    logic [7:0]  enable2;
    logic [7:0]  mode;
    logic [31:0] rdata;
    logic        ack;
    logic        irq;
  } cri_regs_s;

  cri_regs_s st;
  cri_regs_s next_st;
  cri_evt_if evt ();

  logic       access;
  logic       wr_lane0;
  logic [7:0] idx;
  logic [7:0] live1;

  cri_sense u_sense (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .pins_i        ({full_speed_link_i, link_suspended_i, terminal_supply_detect_i,
                     card_supply_detect_i, bus_power_detect_i, busy_line_i,
                     card_presence_i}),
    .fw_event_i    (fw_update_event_i),
    .reader_mode_i (st.mode[cri_pkg::BIT_MODE_READER]),
    .awake_i       (st.mode[cri_pkg::BIT_MODE_AWAKE]),
    .evt           (evt)
  );

  function automatic logic [7:0] word_index(input logic [9:0] adr);
    word_index = adr[9:2];
  endfunction

  assign idx      = word_index(wb_adr_i);
  // one wait state; ack dropped the cycle after it is given
  assign access   = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wr_lane0 = access & wb_we_i & wb_sel_i[0];
  // live levels, reserved bit 7 held at zero
  assign live1    = {1'b0, evt.level} & cri_pkg::LIVE1_USED_MASK;

  always_comb begin
    next_st     = st;
    next_st.ack = access;
    // read clears, but a same-cycle event still sets: set wins
    if (access && !wb_we_i && idx == cri_pkg::IDX_EVENT_REQ_1) begin
      next_st.req1 = 8'h00;
    end
    if (access && !wb_we_i && idx == cri_pkg::IDX_EVENT_REQ_2) begin
      next_st.req2 = 8'h00;
    end
    next_st.req1 = (next_st.req1 | evt.event1) & cri_pkg::REQ1_USED_MASK;
    next_st.req2 = (next_st.req2 | {evt.event_fw, 7'h00}) & cri_pkg::REQ2_USED_MASK;
    if (wr_lane0) begin
      unique case (idx)
        // writes accepted; software must leave these alone
        cri_pkg::IDX_TEST_REG_E: next_st.test_reg_e      = wb_dat_i[7:0];
        cri_pkg::IDX_FW_PORTAL:  next_st.firmware_portal = wb_dat_i[7:0];
        cri_pkg::IDX_ENABLE_1:   next_st.enable1         = wb_dat_i[7:0] & cri_pkg::REQ1_USED_MASK;
        cri_pkg::IDX_ENABLE_2:   next_st.enable2         = wb_dat_i[7:0] & cri_pkg::REQ2_USED_MASK;
        cri_pkg::IDX_MODE_CTRL:  next_st.mode            = {6'h00, wb_dat_i[1:0]};
        default:                 next_st.mode            = st.mode;
      endcase
    end
    next_st.rdata = cri_pkg::UNMAPPED_DATA;
    if (access && !wb_we_i) begin
      unique case (idx)
        cri_pkg::IDX_TEST_REG_E:  next_st.rdata = {24'h000000, st.test_reg_e};
        cri_pkg::IDX_FW_PORTAL:   next_st.rdata = {24'h000000, st.firmware_portal};
        cri_pkg::IDX_EVENT_REQ_1: next_st.rdata = {24'h000000, st.req1};
        cri_pkg::IDX_EVENT_REQ_2: next_st.rdata = {24'h000000, st.req2};
        cri_pkg::IDX_LIVE_COND_1: next_st.rdata = {24'h000000, live1};
        cri_pkg::IDX_ENABLE_1:    next_st.rdata = {24'h000000, st.enable1};
        cri_pkg::IDX_ENABLE_2:    next_st.rdata = {24'h000000, st.enable2};
        cri_pkg::IDX_MODE_CTRL:   next_st.rdata = {24'h000000, st.mode};
        default:                  next_st.rdata = cri_pkg::UNMAPPED_DATA;
      endcase
    end
    next_st.irq = |(next_st.req1 & next_st.enable1) | |(next_st.req2 & next_st.enable2);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign irq_o    = st.irq;

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ack |=> !st.ack)
    else $error("ack held longer than one cycle");
  a_irq_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> |(st.req1 & st.enable1) || |(st.req2 & st.enable2))
    else $error("interrupt without enabled flag");
  a_fs_event_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    evt.event1[6] |=> st.req1[6])
    else $error("full-speed change not flagged");
  a_fs_needs_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.req1[6]) |-> $past(st.mode[0]))
    else $error("full-speed flag outside reader mode");
  a_susp_event_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    evt.event1[5] |=> st.req1[5])
    else $error("suspend change not flagged");
  a_supply_awake_only: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.req1[4]) |-> $past(st.mode[1]))
    else $error("supply flag while asleep");
  a_presence_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    evt.event1[0] |=> st.req1[0])
    else $error("presence change not flagged");
  a_live_levels: assert property (@(posedge clk_i) disable iff (rst_i)
    access && !wb_we_i && idx == cri_pkg::IDX_LIVE_COND_1 |=>
      wb_dat_o[6:2] == $past(evt.level[6:2]))
    else $error("live condition read mismatch");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.req1[7] && st.req2[6:0] == 7'h00)
    else $error("reserved bit set");
  a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    access && !wb_we_i && idx == cri_pkg::IDX_EVENT_REQ_1 && evt.event1 == 8'h00 |=>
      st.req1 == 8'h00)
    else $error("read did not clear flags");
  a_read_keeps_event: assert property (@(posedge clk_i) disable iff (rst_i)
    access && !wb_we_i && idx == cri_pkg::IDX_EVENT_REQ_2 |=>
      st.req2[7] == $past(evt.event_fw))
    else $error("event lost during read");
endmodule

//--- common/cri_pkg.sv
// constants for the card reader event-request and live-condition register group
// assumes a classic wishbone slave, 8-bit registers at word addresses, one 125 MHz clock
// Contract
// - full-speed link change sets event_request_1 bit 6, card reader mode only
// - suspend/resume change sets event_request_1 bit 5, card reader mode only
// - terminal, card supply, bus power, busy changes set bits 4,3,2,1 while awake
// - card presence change sets event_request_1 bit 0, card reader mode only
// - live_condition_1 bit 6 reads 1 only for an active full-speed connection
// - live_condition_1 bits 4,3,2 read 1 while the matching supply is present
// - reserved bits of both request registers and live_condition_1 read only
// - a request flag reaches the interrupt output only when its enable is 1
package cri_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  IDX_TEST_REG_E  = 8'h0e;
  localparam logic [7:0]  IDX_FW_PORTAL   = 8'h0f;
  localparam logic [7:0]  IDX_EVENT_REQ_1 = 8'h10;
  localparam logic [7:0]  IDX_EVENT_REQ_2 = 8'h11;
  localparam logic [7:0]  IDX_LIVE_COND_1 = 8'h12;
  localparam logic [7:0]  IDX_ENABLE_1    = 8'h20;
  localparam logic [7:0]  IDX_ENABLE_2    = 8'h21;
  localparam logic [7:0]  IDX_MODE_CTRL   = 8'h22;
  localparam int          BIT_FULL_SPEED  = 6;
  localparam int          BIT_SUSPENDED   = 5;
  localparam int          BIT_TERMINAL    = 4;
  localparam int          BIT_CARD_SUPPLY = 3;
  localparam int          BIT_BUS_POWER   = 2;
  localparam int          BIT_BUSY        = 1;
  localparam int          BIT_PRESENCE    = 0;
  localparam int          BIT_FW_UPDATE   = 7;
  localparam int          BIT_MODE_READER = 0;
  localparam int          BIT_MODE_AWAKE  = 1;
  localparam logic [7:0]  REQ1_USED_MASK  = 8'h7f;
  localparam logic [7:0]  REQ2_USED_MASK  = 8'h80;
  localparam logic [7:0]  LIVE1_USED_MASK = 8'h7f;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
endpackage

//--- common/cri_evt_if.sv
`timescale 1ns/1ps
// carries synchronised condition levels and gated event strobes
// assumes one clock shared by both ends
interface cri_evt_if;
  logic [6:0] level;
  logic [7:0] event1;
  logic       event_fw;
  modport src (output level, output event1, output event_fw);
  modport dst (input  level, input  event1, input  event_fw);
endinterface

//--- logic/cri_sense.sv
`timescale 1ns/1ps
// synchronises condition pins and turns level changes into qualified events
// assumes pins are asynchronous to clk_i
module cri_sense (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [6:0] pins_i,
  input  wire logic       fw_event_i,
  input  wire logic       reader_mode_i,
  input  wire logic       awake_i,
  cri_evt_if.src          evt
);
  typedef struct packed {
    logic [6:0] meta;
    logic [6:0] sync;
    logic [6:0] last;
    logic       fw_meta;
    logic       fw_sync;
    logic       fw_last;
  } cri_sense_s;

  cri_sense_s st;
  cri_sense_s next_st;
  logic [6:0] change;

  // only the sync and last stages feed compare logic
  always_comb begin
    next_st         = st;
    next_st.meta    = pins_i;
    next_st.sync    = st.meta;
    next_st.last    = st.sync;
    next_st.fw_meta = fw_event_i;
    next_st.fw_sync = st.fw_meta;
    next_st.fw_last = st.fw_sync;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign change    = st.sync ^ st.last;
  assign evt.level = st.sync;
  assign evt.event_fw = st.fw_sync & ~st.fw_last;
  assign evt.event1[7] = 1'b0;
  assign evt.event1[cri_pkg::BIT_FULL_SPEED]  = change[cri_pkg::BIT_FULL_SPEED] & reader_mode_i;
  assign evt.event1[cri_pkg::BIT_SUSPENDED]   = change[cri_pkg::BIT_SUSPENDED] & reader_mode_i;
  assign evt.event1[cri_pkg::BIT_TERMINAL]    = change[cri_pkg::BIT_TERMINAL] & awake_i;
  assign evt.event1[cri_pkg::BIT_CARD_SUPPLY] = change[cri_pkg::BIT_CARD_SUPPLY] & awake_i;
  assign evt.event1[cri_pkg::BIT_BUS_POWER]   = change[cri_pkg::BIT_BUS_POWER] & awake_i;
  assign evt.event1[cri_pkg::BIT_BUSY]        = change[cri_pkg::BIT_BUSY] & awake_i;
  assign evt.event1[cri_pkg::BIT_PRESENCE]    = change[cri_pkg::BIT_PRESENCE] & reader_mode_i;
endmodule

//--- sim/cri_host_model.sv
// host model: runs classic wishbone single cycles into the register group
// assumes one clock; the bench top calls xfer hierarchically
`timescale 1ns/1ps
module cri_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [9:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    rd = 8'h00;
    // test and portal places are never written by software
    if (w && (idx == cri_pkg::IDX_TEST_REG_E || idx == cri_pkg::IDX_FW_PORTAL)) return;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'b00};
    sel_o <= 4'h1;
    dat_o <= {24'h000000, wd};
    // held until ack is seen high at a rising edge; only the bench watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    rd = dat_i[7:0];
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

//--- sim/card_reader_irq_status_regs_tb.sv
// bench for the event-request and live-condition registers
// assumes the host model in cri_host_model.sv and the package constants
`timescale 1ns/1ps
module card_reader_irq_status_regs_tb;
  logic        clk_i;
  logic        rst_i;
  logic [6:0]  pins;
  logic        fw_evt;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  int          fails;
  int          checks_done;
  int          i;

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  cri_host_model host_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
                         .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  cri_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .full_speed_link_i(pins[6]), .link_suspended_i(pins[5]),
    .terminal_supply_detect_i(pins[4]), .card_supply_detect_i(pins[3]),
    .bus_power_detect_i(pins[2]), .busy_line_i(pins[1]), .card_presence_i(pins[0]),
    .fw_update_event_i(fw_evt), .irq_o(irq));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] v;
    host_u.xfer(1'b0, idx, 8'h00, v);
    chk(what, exp, v);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    logic [7:0] v;
    host_u.xfer(1'b1, idx, val, v);
  endtask

  // two sync flops plus the flag edge, with one spare
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic end_sim;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 8);
    fails++;
    end_sim();
  end

  initial begin
    fails = 0;
    checks_done = 0;
    pins = 7'h00;
    fw_evt = 1'b0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(cri_pkg::IDX_TEST_REG_E, 8'h00, "test_reg_e");
    rd(cri_pkg::IDX_FW_PORTAL, 8'h00, "firmware_portal");
    rd(cri_pkg::IDX_EVENT_REQ_1, 8'h00, "event_request_1");
    rd(cri_pkg::IDX_EVENT_REQ_2, 8'h00, "event_request_2");
    rd(cri_pkg::IDX_LIVE_COND_1, 8'h00, "live_condition_1");
    rd(8'h30, 8'h00, "unmapped");
    wr(cri_pkg::IDX_MODE_CTRL, 8'h03);
    wr(cri_pkg::IDX_ENABLE_1, 8'h7f);
    wr(cri_pkg::IDX_ENABLE_2, 8'h80);
    rd(cri_pkg::IDX_ENABLE_1, 8'h7f, "enable1");
    // raise each condition in turn, earlier ones kept high; flag, clear-on-read and level in turn
    for (i = 0; i < 7; i++) begin
      pins[i] <= 1'b1;
      settle();
      chk("irq", 8'h01, {7'h00, irq});
      rd(cri_pkg::IDX_EVENT_REQ_1, 8'(8'h01 << i), "event_request_1");
      rd(cri_pkg::IDX_EVENT_REQ_1, 8'h00, "event_request_1 cleared");
      rd(cri_pkg::IDX_LIVE_COND_1, 8'((8'h02 << i) - 8'h01), "live_condition_1");
    end
    wr(cri_pkg::IDX_ENABLE_1, 8'h00);
    pins[0] <= 1'b0;
    settle();
    chk("irq masked", 8'h00, {7'h00, irq});
    rd(cri_pkg::IDX_EVENT_REQ_1, 8'h01, "event_request_1 masked");
    // out of reader mode and asleep: changes must not flag, levels still show
    wr(cri_pkg::IDX_MODE_CTRL, 8'h00);
    pins[6] <= 1'b0;
    pins[4] <= 1'b0;
    settle();
    rd(cri_pkg::IDX_EVENT_REQ_1, 8'h00, "event_request_1 gated");
    rd(cri_pkg::IDX_LIVE_COND_1, 8'h2e, "live_condition_1");
    wr(cri_pkg::IDX_EVENT_REQ_1, 8'hff);
    rd(cri_pkg::IDX_EVENT_REQ_1, 8'h00, "event_request_1 write");
    wr(cri_pkg::IDX_LIVE_COND_1, 8'hff);
    rd(cri_pkg::IDX_LIVE_COND_1, 8'h2e, "live_condition_1 write");
    fw_evt <= 1'b1;
    settle();
    chk("irq second", 8'h01, {7'h00, irq});
    rd(cri_pkg::IDX_EVENT_REQ_2, 8'h80, "event_request_2");
    rd(cri_pkg::IDX_EVENT_REQ_2, 8'h00, "event_request_2 cleared");
    // new edge timed to reach the flag in the very cycle the read is taken
    fw_evt <= 1'b0;
    settle();
    fw_evt <= 1'b1;
    @(posedge clk_i);
    rd(cri_pkg::IDX_EVENT_REQ_2, 8'h00, "event_request_2 during read");
    rd(cri_pkg::IDX_EVENT_REQ_2, 8'h80, "event_request_2 kept");
    end_sim();
  end
endmodule
